//--- hw/cfb_pkg.sv
// Shared constants for the configurable first-in first-out buffer.
// Assumes a 32-bit APB slave with byte addresses and word-aligned registers.
package cfb_pkg;

	// ==========================================================
	// Register byte offsets
	localparam logic [7:0]  CFB_OFS_CTRL   = 8'h00;
	localparam logic [7:0]  CFB_OFS_STATUS = 8'h04;
	localparam logic [7:0]  CFB_OFS_COUNT  = 8'h08;

	// ==========================================================
	// Control register fields
	localparam int          CFB_CTRL_FLUSH = 0;   // Write 1: empty the buffer
	localparam int          CFB_CTRL_INJS  = 1;   // Inject single-bit error on writes
	localparam int          CFB_CTRL_INJD  = 2;   // Inject double-bit error on writes

	// ==========================================================
	// Status register fields
	localparam int          CFB_ST_FULL    = 0;
	localparam int          CFB_ST_EMPTY   = 1;
	localparam int          CFB_ST_AFULL   = 2;
	localparam int          CFB_ST_AEMPTY  = 3;
	localparam int          CFB_ST_PFULL   = 4;
	localparam int          CFB_ST_PEMPTY  = 5;
	localparam int          CFB_ST_SBIT    = 8;   // Sticky, write 1 to clear
	localparam int          CFB_ST_DBIT    = 9;   // Sticky, write 1 to clear
	localparam int          CFB_ST_OVF     = 10;  // Sticky, write 1 to clear

	// ==========================================================
	// Count register fields
	localparam int          CFB_CNT_WR_LSB = 0;
	localparam int          CFB_CNT_RD_LSB = 16;

	// ==========================================================
	// Reset values and configuration encodings
	localparam logic [31:0] CFB_CTRL_RST   = 32'h0000_0000;
	localparam logic [31:0] CFB_ZERO_WORD  = 32'h0000_0000;
	localparam int          CFB_PROG_NONE  = 0;
	localparam int          CFB_PROG_ONE   = 1;   // Single threshold constant
	localparam int          CFB_PROG_TWO   = 2;   // Assert and negate constants
	localparam int          CFB_SYNC_STAGES = 2;  // Read-side count lag stages

endpackage : cfb_pkg

//--- hw/cfb_fifo.sv
// Configurable FIFO with ECC, fall-through read mode, programmable flags and APB status.
// Assumes one clock for writer, reader and APB; writer and reader obey full and empty.
//
// Contract
// (R1) Write width 1..1024, else elaboration fails
// (R2) Write depth power of two, 16..131072
// (R3) Read depth derived from widths and depth
// (R4) Standard or fall-through registered read mode
// (R5) ECC encodes on write, corrects on read
// (R6) Single-bit injection flagged on read
// (R7) Double-bit injection flagged on read
// (R8) Embedded register adds one read cycle; the code applies it in standard mode only, not in fall-through
// (R9) Reset sync optional; separate side resets
// (R10) Async or sync reset, reset optional
// (R11) Full flags take configured reset level
// (R12) Optional output word reset value
// (R13) Almost full: exactly one slot left
// (R14) Almost empty: exactly one word left
// (R15) Write acknowledge, configurable polarity
// (R16) Overflow on refused write, configurable polarity
// (R17) Prog full: one or two thresholds
// (R18) Prog empty: one or two thresholds
// (R19) Fall-through counts include output word
// (R20) Write count width 1..log2 depth
// (R21) Read count width 1..log2 read depth
// (R22) Counts updated in own side
// (R23) Read count lags, settles when idle
// (R24) Refused accesses leave pointers unchanged
// (R25) Writer and reader respect full, empty
`timescale 1ns/1ns
module cfb_fifo
	import cfb_pkg::*;
#(
	parameter int            WR_WIDTH     = 32,
	parameter int            WR_DEPTH     = 512,
	parameter int            RD_WIDTH     = 32,
	parameter bit            FALL_THROUGH = 1'b0,
	parameter bit            USE_ECC      = 1'b1,
	parameter bit            EMB_REG      = 1'b0,
	parameter bit            HAS_RST      = 1'b1,
	parameter bit            RST_SYNC     = 1'b1,
	parameter bit            ASYNC_RST    = 1'b1,
	parameter bit            FULL_RST_VAL = 1'b1,
	parameter bit            USE_DOUT_RST = 1'b1,
	parameter logic [WR_WIDTH-1:0] DOUT_RST_VAL = '0,
	parameter bit            ACK_LOW      = 1'b0,
	parameter bit            OVF_LOW      = 1'b0,
	parameter int            PF_TYPE      = cfb_pkg::CFB_PROG_TWO,
	parameter int            PF_ASSERT    = WR_DEPTH - 4,
	parameter int            PF_NEGATE    = WR_DEPTH - 8,
	parameter int            PE_TYPE      = cfb_pkg::CFB_PROG_TWO,
	parameter int            PE_ASSERT    = 4,
	parameter int            PE_NEGATE    = 8,
	parameter int            WR_CNT_W     = $clog2(WR_DEPTH),
	parameter int            RD_CNT_W     = $clog2(WR_DEPTH)
)(
	input  wire logic                i_clk,
	input  wire logic                i_rstn,
	input  wire logic                i_wr_rstn,
	input  wire logic                i_rd_rstn,
	input  wire logic                i_wr_en,
	input  wire logic [WR_WIDTH-1:0] i_wr_data,
	input  wire logic                i_inj_sbit,
	input  wire logic                i_inj_dbit,
	input  wire logic                i_rd_en,
	output logic      [WR_WIDTH-1:0] o_rd_data,
	output logic                     o_full,
	output logic                     o_almost_full,
	output logic                     o_prog_full,
	output logic                     o_empty,
	output logic                     o_almost_empty,
	output logic                     o_prog_empty,
	output logic                     o_wr_ack,
	output logic                     o_overflow,
	output logic                     o_sbit_err,
	output logic                     o_dbit_err,
	output logic      [WR_CNT_W-1:0] o_wr_count,
	output logic      [RD_CNT_W-1:0] o_rd_count,
	input  wire logic                psel,
	input  wire logic                penable,
	input  wire logic                pwrite,
	input  wire logic [7:0]          paddr,
	input  wire logic [31:0]         pwdata,
	output logic      [31:0]         prdata,
	output logic                     pready,
	output logic                     pslverr
);
	import cfb_pkg::*;

	// ==========================================================
	// Geometry and configuration checks
	localparam int AW       = $clog2(WR_DEPTH);
	localparam int RD_DEPTH = (WR_DEPTH * WR_WIDTH) / RD_WIDTH;  // [R3]
	localparam int PB       = calc_p(WR_WIDTH);
	localparam int CW       = WR_WIDTH + PB + 1;
	localparam int MW       = USE_ECC ? CW : WR_WIDTH;
	localparam logic [AW:0] DEPTH_V = (AW+1)'(WR_DEPTH);

	// Non-symmetric ports are not built; read width must match write width
	generate
		if (WR_WIDTH < 1 || WR_WIDTH > 1024)
			$error("write width out of range");  // [R1]
		if (WR_DEPTH < 16 || WR_DEPTH > 131072 || (WR_DEPTH & (WR_DEPTH - 1)) != 0)
			$error("write depth not a legal power of two");  // [R2]
		if (RD_WIDTH != WR_WIDTH || RD_DEPTH != WR_DEPTH)
			$error("read width must equal write width");  // [R3]
		if (WR_CNT_W < 1 || WR_CNT_W > AW)
			$error("write count width out of range");  // [R20]
		if (RD_CNT_W < 1 || RD_CNT_W > $clog2(RD_DEPTH))
			$error("read count width out of range");  // [R21]
	endgenerate

	// ==========================================================
	// ECC helpers: Hamming code plus overall parity in bit 0
	function automatic int calc_p(input int w);
		int p;
		p = 2;
		while ((1 << p) < (w + p + 1))
			p++;
		return p;
	endfunction : calc_p

	function automatic logic [CW-1:0] ecc_enc(input logic [WR_WIDTH-1:0] d);
		logic [CW-1:0] c;
		int            k;
		c = '0;
		k = 0;
		for (int i = 1; i < CW; i++)
			if ((i & (i - 1)) != 0)
			begin
				c[i] = d[k];
				k++;
			end
		for (int j = 0; j < PB; j++)
			for (int i = 1; i < CW; i++)
				if (((i >> j) & 1) == 1 && (i & (i - 1)) != 0)
					c[1 << j] = c[1 << j] ^ c[i];
		c[0] = ^c[CW-1:1];
		return c;
	endfunction : ecc_enc

	// Returns {double error, single error, corrected data}
	function automatic logic [WR_WIDTH+1:0] ecc_dec(input logic [CW-1:0] cin);
		logic [CW-1:0]       c;
		logic [WR_WIDTH-1:0] d;
		int                  syn;
		int                  k;
		logic                par;
		logic                se;
		logic                de;
		c   = cin;
		d   = '0;
		syn = 0;
		k   = 0;
		par = ^cin;
		for (int i = 1; i < CW; i++)
			if (c[i])
				syn = syn ^ i;
		se = par;
		de = (syn != 0) && !par;
		if (par && syn != 0 && syn < CW)
			c[syn] = ~c[syn];  // Correct single flipped bit
		for (int i = 1; i < CW; i++)
			if ((i & (i - 1)) != 0)
			begin
				d[k] = c[i];
				k++;
			end
		return {de, se, d};
	endfunction : ecc_dec

	// ==========================================================
	// Reset: two-flop release, then side resets picked per configuration
	logic rst_meta;
	logic rst_sync;
	logic wr_rst_n;
	logic rd_rst_n;
	logic wr_arst_n;
	logic rd_arst_n;
	logic wr_srst;
	logic rd_srst;

	always_ff @(posedge i_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			rst_meta <= 1'b0;
			rst_sync <= 1'b0;
		end
		else
		begin
			rst_meta <= 1'b1;
			rst_sync <= rst_meta;
		end
	end

	// Without synchronisation each side takes its own raw reset
	assign wr_rst_n  = !HAS_RST ? 1'b1 : (RST_SYNC ? rst_sync : i_wr_rstn);  // [R9] [R10]
	assign rd_rst_n  = !HAS_RST ? 1'b1 : (RST_SYNC ? rst_sync : i_rd_rstn);  // [R9] [R10]
	assign wr_arst_n = ASYNC_RST ? wr_rst_n : 1'b1;  // [R10]
	assign rd_arst_n = ASYNC_RST ? rd_rst_n : 1'b1;
	assign wr_srst   = !ASYNC_RST && !wr_rst_n;      // [R10]
	assign rd_srst   = !ASYNC_RST && !rd_rst_n;

	// ==========================================================
	// APB control bits
	logic [31:0] ctrl;
	logic        flush;
	logic        apb_wr;
	logic        sticky_s;
	logic        sticky_d;
	logic        sticky_o;

	assign apb_wr = psel && penable && pready && pwrite;
	assign flush  = apb_wr && paddr == CFB_OFS_CTRL && pwdata[CFB_CTRL_FLUSH];

	// ==========================================================
	// Storage and pointers
	logic [MW-1:0] mem [WR_DEPTH];
	logic [AW:0]   wptr;
	logic [AW:0]   rptr;
	logic [AW:0]   next_wptr;
	logic [AW:0]   next_rptr;
	logic [AW:0]   mem_cnt;
	logic          out_valid;
	logic          next_out_valid;
	logic          wr_take;
	logic          mem_pop;
	logic          rd_pop;
	logic          inj_s;
	logic          inj_d;
	logic [MW-1:0] wr_word;
	logic [CW-1:0] enc;
	logic [WR_WIDTH+1:0] rd_dec;

	assign mem_cnt = wptr - rptr;
	assign wr_take = i_wr_en && !o_full;  // [R24]
	assign inj_s   = i_inj_sbit || ctrl[CFB_CTRL_INJS];
	assign inj_d   = i_inj_dbit || ctrl[CFB_CTRL_INJD];

	// Injection flips codeword bits: one data bit, or two check bits
	always_comb
	begin
		enc = ecc_enc(i_wr_data);  // [R5]
		if (inj_d)
			enc = enc ^ CW'(6);  // [R7]
		else if (inj_s)
			enc = enc ^ CW'(8);  // [R6]
		wr_word = USE_ECC ? MW'(enc) : MW'(i_wr_data);
	end

	// Read port decode; bypass when ECC is off
	always_comb
	begin
		if (USE_ECC)
			rd_dec = ecc_dec(CW'(mem[rptr[AW-1:0]]));  // [R5]
		else
			rd_dec = {2'b00, WR_WIDTH'(mem[rptr[AW-1:0]])};
	end

	// Fall-through keeps the head word in the output stage
	always_comb
	begin
		rd_pop         = i_rd_en && !o_empty;  // [R24]
		mem_pop        = 1'b0;
		next_out_valid = out_valid;
		if (FALL_THROUGH)
		begin
			if (rd_pop)
				next_out_valid = 1'b0;
			if ((!out_valid || rd_pop) && mem_cnt != '0)
			begin
				mem_pop        = 1'b1;  // [R4]
				next_out_valid = 1'b1;
			end
		end
		else
			mem_pop = rd_pop;
		next_wptr = wptr + (AW+1)'(wr_take);
		next_rptr = rptr + (AW+1)'(mem_pop);
	end

	// Memory write port; contents need no reset
	always_ff @(posedge i_clk)
	begin
		if (wr_take)
			mem[wptr[AW-1:0]] <= wr_word;
	end

	// ==========================================================
	// Write side: pointer, full flags, handshake, write count
	logic [AW:0] wr_cnt_next;

	// Write count and prog full see stored words plus a held fall-through word; o_full and o_almost_full see stored words only
	assign wr_cnt_next = next_wptr - next_rptr + (AW+1)'(FALL_THROUGH && next_out_valid);  // [R19]

	always_ff @(posedge i_clk or negedge wr_arst_n)
	begin
		if (!wr_arst_n)
		begin
			wptr          <= '0;
			o_full        <= FULL_RST_VAL;  // [R11]
			o_almost_full <= FULL_RST_VAL;  // [R11]
			o_prog_full   <= FULL_RST_VAL;  // [R11]
			o_wr_ack      <= ACK_LOW;
			o_overflow    <= OVF_LOW;
			o_wr_count    <= '0;
		end
		else if (wr_srst)
		begin
			wptr          <= '0;
			o_full        <= FULL_RST_VAL;
			o_almost_full <= FULL_RST_VAL;
			o_prog_full   <= FULL_RST_VAL;
			o_wr_ack      <= ACK_LOW;
			o_overflow    <= OVF_LOW;
			o_wr_count    <= '0;
		end
		else
		begin
			wptr          <= flush ? '0 : next_wptr;
			o_full        <= !flush && (next_wptr - next_rptr) == DEPTH_V;
			o_almost_full <= !flush && (next_wptr - next_rptr) == DEPTH_V - 1'b1;  // [R13]
			o_wr_ack      <= wr_take ^ ACK_LOW;                 // [R15]
			o_overflow    <= (i_wr_en && o_full) ^ OVF_LOW;     // [R16]
			o_wr_count    <= flush ? '0 : wr_cnt_next[AW -: WR_CNT_W];  // [R20] [R22]
			if (flush || PF_TYPE == CFB_PROG_NONE)
				o_prog_full <= 1'b0;
			else if (wr_cnt_next >= (AW+1)'(PF_ASSERT))
				o_prog_full <= 1'b1;  // [R17]
			else if (PF_TYPE == CFB_PROG_ONE || wr_cnt_next < (AW+1)'(PF_NEGATE))
				o_prog_full <= 1'b0;  // [R17]
		end
	end

	// ==========================================================
	// Read side: pointer, empty flags, lagging read count
	logic [AW:0]   rd_cnt_next;
	logic [AW:0]   rd_cnt_lag [CFB_SYNC_STAGES];
	logic          empty_next;

	assign rd_cnt_next = next_wptr - next_rptr + (AW+1)'(FALL_THROUGH && next_out_valid);  // [R19]
	assign empty_next  = FALL_THROUGH ? !next_out_valid : (next_wptr == next_rptr);

	always_ff @(posedge i_clk or negedge rd_arst_n)
	begin
		if (!rd_arst_n)
		begin
			rptr           <= '0;
			out_valid      <= 1'b0;
			o_empty        <= 1'b1;
			o_almost_empty <= 1'b0;
			o_prog_empty   <= 1'b1;
			o_rd_count     <= '0;
			for (int s = 0; s < CFB_SYNC_STAGES; s++)
				rd_cnt_lag[s] <= '0;
		end
		else if (rd_srst)
		begin
			rptr           <= '0;
			out_valid      <= 1'b0;
			o_empty        <= 1'b1;
			o_almost_empty <= 1'b0;
			o_prog_empty   <= 1'b1;
			o_rd_count     <= '0;
			for (int s = 0; s < CFB_SYNC_STAGES; s++)
				rd_cnt_lag[s] <= '0;
		end
		else
		begin
			rptr           <= flush ? '0 : next_rptr;
			out_valid      <= !flush && next_out_valid;
			o_empty        <= flush || empty_next;
			o_almost_empty <= !flush && rd_cnt_next == (AW+1)'(1);  // [R14]
			// Read count trails the write side, settling once traffic stops
			rd_cnt_lag[0]  <= flush ? '0 : rd_cnt_next;  // [R22] [R23]
			for (int s = 1; s < CFB_SYNC_STAGES; s++)
				rd_cnt_lag[s] <= rd_cnt_lag[s-1];
			o_rd_count     <= rd_cnt_lag[CFB_SYNC_STAGES-1][AW -: RD_CNT_W];  // [R21] [R23]
			if (flush || PE_TYPE == CFB_PROG_NONE)
				o_prog_empty <= flush;
			else if (rd_cnt_next <= (AW+1)'(PE_ASSERT))
				o_prog_empty <= 1'b1;  // [R18]
			else if (PE_TYPE == CFB_PROG_ONE || rd_cnt_next > (AW+1)'(PE_NEGATE))
				o_prog_empty <= 1'b0;  // [R18]
		end
	end

	// ==========================================================
	// Output word path: decode stage, optional embedded stage
	logic [WR_WIDTH+1:0] stage;
	logic [WR_WIDTH+1:0] stage_emb;
	logic                stage_ld;
	logic                emb_ld;
	logic [WR_WIDTH+1:0] out_word;

	assign stage_ld = mem_pop;
	assign out_word = EMB_REG && !FALL_THROUGH ? stage_emb : stage;  // [R8]

	// Standard mode: word appears two cycles after the read request, three with EMB_REG
	always_ff @(posedge i_clk or negedge rd_arst_n)
	begin
		if (!rd_arst_n)
		begin
			stage_emb <= '0;
			emb_ld    <= 1'b0;
		end
		else if (rd_srst)
		begin
			stage_emb <= '0;
			emb_ld    <= 1'b0;
		end
		else
		begin
			emb_ld    <= stage_ld;
			if (emb_ld)
				stage_emb <= stage;  // [R8]
		end
	end

	// Stage and flags; output word reset is optional, so kept apart
	generate
		if (USE_DOUT_RST && HAS_RST)
		begin : g_dout_rst
			always_ff @(posedge i_clk or negedge rd_arst_n)
			begin
				if (!rd_arst_n)
					stage <= {2'b00, DOUT_RST_VAL};  // [R12]
				else if (rd_srst)
					stage <= {2'b00, DOUT_RST_VAL};  // [R12]
				else if (stage_ld)
					stage <= rd_dec;  // [R4]
			end
		end
		else
		begin : g_dout_hold
			// Holds its value through reset
			always_ff @(posedge i_clk)
			begin
				if (stage_ld)
					stage <= rd_dec;  // [R12]
			end
		end
	endgenerate

	// Final output flops; reset load only when configured
	always_ff @(posedge i_clk)
	begin
		if (USE_DOUT_RST && HAS_RST && !rd_rst_n)
		begin
			o_rd_data  <= DOUT_RST_VAL;  // [R12]
			o_sbit_err <= 1'b0;
			o_dbit_err <= 1'b0;
		end
		else if (rd_rst_n)  // Without an output reset the word rides through reset [R12]
		begin
			o_rd_data  <= out_word[WR_WIDTH-1:0];
			o_sbit_err <= USE_ECC && out_word[WR_WIDTH];    // [R6]
			o_dbit_err <= USE_ECC && out_word[WR_WIDTH+1];  // [R7]
		end
	end

	// ==========================================================
	// APB slave: one wait-free access phase, registered answer
	logic        hit;
	logic [31:0] rdval;
	logic [31:0] stat;

	assign hit = paddr == CFB_OFS_CTRL || paddr == CFB_OFS_STATUS
		|| paddr == CFB_OFS_COUNT;

	always_comb
	begin
		stat                 = CFB_ZERO_WORD;
		stat[CFB_ST_FULL]    = o_full;
		stat[CFB_ST_EMPTY]   = o_empty;
		stat[CFB_ST_AFULL]   = o_almost_full;
		stat[CFB_ST_AEMPTY]  = o_almost_empty;
		stat[CFB_ST_PFULL]   = o_prog_full;
		stat[CFB_ST_PEMPTY]  = o_prog_empty;
		stat[CFB_ST_SBIT]    = sticky_s;
		stat[CFB_ST_DBIT]    = sticky_d;
		stat[CFB_ST_OVF]     = sticky_o;
		rdval                = CFB_ZERO_WORD;
		case (paddr)
			CFB_OFS_CTRL:   rdval = ctrl;
			CFB_OFS_STATUS: rdval = stat;
			CFB_OFS_COUNT:
			begin
				rdval[CFB_CNT_WR_LSB +: WR_CNT_W] = o_wr_count;
				rdval[CFB_CNT_RD_LSB +: RD_CNT_W] = o_rd_count;
			end
			default:        rdval = CFB_ZERO_WORD;
		endcase
	end

	// Flush bit self-clears; injection bits stay as written
	always_ff @(posedge i_clk or negedge rst_sync)
	begin
		if (!rst_sync)
		begin
			ctrl    <= CFB_CTRL_RST;
			pready  <= 1'b0;
			prdata  <= CFB_ZERO_WORD;
			pslverr <= 1'b0;
		end
		else
		begin
			pready  <= psel && !penable;
			prdata  <= (psel && !penable && !pwrite) ? rdval : CFB_ZERO_WORD;
			pslverr <= psel && !penable && !hit;
			if (apb_wr && paddr == CFB_OFS_CTRL)
				ctrl <= {29'h0000_0000, pwdata[CFB_CTRL_INJD:CFB_CTRL_INJS], 1'b0};
		end
	end

	// Sticky error bits: a new event wins over a clear in the same cycle
	always_ff @(posedge i_clk or negedge rst_sync)
	begin
		if (!rst_sync)
		begin
			sticky_s <= 1'b0;
			sticky_d <= 1'b0;
			sticky_o <= 1'b0;
		end
		else
		begin
			if (o_sbit_err)
				sticky_s <= 1'b1;
			else if (apb_wr && paddr == CFB_OFS_STATUS && pwdata[CFB_ST_SBIT])
				sticky_s <= 1'b0;
			if (o_dbit_err)
				sticky_d <= 1'b1;
			else if (apb_wr && paddr == CFB_OFS_STATUS && pwdata[CFB_ST_DBIT])
				sticky_d <= 1'b0;
			if (i_wr_en && o_full)
				sticky_o <= 1'b1;  // [R16]
			else if (apb_wr && paddr == CFB_OFS_STATUS && pwdata[CFB_ST_OVF])
				sticky_o <= 1'b0;
		end
	end

endmodule : cfb_fifo

//--- verification/cfb_user_model.sv
// User logic on the far side: one writer and one reader of data words.
// Assumes the bench steers intent and may switch flag obedience off.
`timescale 1ns/1ns
module cfb_user_model (
	input  wire logic        i_want_wr,
	input  wire logic        i_want_rd,
	input  wire logic        i_obey,
	input  wire logic [31:0] i_data,
	input  wire logic        i_full,
	input  wire logic        i_empty,
	output logic             o_wr_en,
	output logic             o_rd_en,
	output logic      [31:0] o_wr_data
);
	// ====================
	// Request gating
	// Obedience off exists only so that refusals can be provoked
	assign o_wr_en   = i_want_wr && (!i_obey || !i_full);
	assign o_rd_en   = i_want_rd && (!i_obey || !i_empty);
	// Idle data inverted, so a stale word never passes for a fresh one
	assign o_wr_data = o_wr_en ? i_data : ~i_data;
endmodule : cfb_user_model

//--- verification/cfb_fifo_asserts.sv
// Port-level checker for the buffer, bound onto cfb_fifo.
// Assumes one clock and the active-low reset input.
`timescale 1ns/1ns
module cfb_fifo_asserts #(
	parameter int WR_WIDTH = 32
)(
	input wire logic                i_clk,
	input wire logic                i_rstn,
	input wire logic                i_wr_en,
	input wire logic                i_rd_en,
	input wire logic [WR_WIDTH-1:0] o_rd_data,
	input wire logic                o_full,
	input wire logic                o_almost_full,
	input wire logic                o_prog_full,
	input wire logic                o_empty,
	input wire logic                o_almost_empty,
	input wire logic                o_wr_ack,
	input wire logic                o_overflow,
	input wire logic                o_sbit_err,
	input wire logic                o_dbit_err
);
	logic rd_take;
	// Read that the buffer accepts
	assign rd_take = i_rd_en && !o_empty;
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (!i_rstn);
	// ====================
	// Write side
	a_ack_taken:
	assert property (i_wr_en && !o_full |=> o_wr_ack)
		else $error("accepted write not acknowledged");
	a_ack_cause:
	assert property (o_wr_ack |-> $past(i_wr_en) && !$past(o_full))
		else $error("ack without accepted write");
	a_ovf_refused:
	assert property (i_wr_en && o_full |=> o_overflow && !o_wr_ack)
		else $error("refused write not flagged");
	a_full_via_afull:
	assert property ($rose(o_full) |-> $past(o_almost_full))
		else $error("full without almost full first");
	a_rst_full_level:
	assert property ($rose(i_rstn) |-> o_full && o_almost_full && o_prog_full)
		else $error("full flags not at reset level");
	// ====================
	// Read side and covers
	a_empty_via_aempty:
	assert property ($rose(o_empty) |-> $past(o_almost_empty))
		else $error("empty without almost empty first");
	a_empty_read_ign:
	assert property (i_rd_en && o_empty && !i_wr_en |=> o_empty)
		else $error("read while empty changed state");
	a_rd_data_hold:
	assert property (!$past(rd_take, 2) |-> $stable(o_rd_data))
		else $error("read data moved without a read");
	a_err_excl:
	assert property (o_dbit_err |-> !o_sbit_err)
		else $error("single and double error together");
	c_overflow: cover property (o_full ##1 o_overflow);
	c_sbit: cover property (o_sbit_err);
	c_dbit: cover property (o_dbit_err);
endmodule : cfb_fifo_asserts

//--- verification/cfb_fifo_tb.sv
// Self-checking bench: reference model, scoreboard and APB status.
// Assumes cfb_pkg, the user model and the checker compile first.
`timescale 1ns/1ns
module cfb_fifo_tb;
	import cfb_pkg::*;
	localparam logic [31:0] RSTV = 32'h0000_00a5;
	typedef struct {logic [31:0] d; logic sb; logic db;} cfb_exp_s;
	logic        i_clk = 0, i_rstn = 0, i_inj_sbit = 0, i_inj_dbit = 0;
	logic        psel = 0, penable = 0, pwrite = 0, pready, pslverr, er;
	logic        want_wr = 0, want_rd = 0, obey = 1, i_wr_en, i_rd_en;
	logic        o_full, o_almost_full, o_prog_full, o_empty, o_almost_empty;
	logic        o_prog_empty, o_wr_ack, o_overflow, o_sbit_err, o_dbit_err;
	logic        pf, pe, wacc, racc, eack, eovf;
	logic [1:0]  due = 0;
	logic [3:0]  ef, o_wr_count, o_rd_count;
	logic [7:0]  paddr = 0;
	logic [31:0] pwdata = 0, wdat = 0, prdata, rd, r, i_wr_data, o_rd_data;
	logic [31:0] seed = 32'd80914;
	int          err_total = 0, num_checks = 0, cnt = 0, idle = 0, rel = 0;
	cfb_exp_s    q[$], e;

	always #25 i_clk = ~i_clk;

	// ====================
	// Design and user model
	cfb_fifo #(.WR_DEPTH(16), .DOUT_RST_VAL(RSTV)) cfb_fifo_i (
		.i_clk, .i_rstn, .i_wr_rstn(1'b1), .i_rd_rstn(1'b1), .i_wr_en, .i_wr_data,
		.i_inj_sbit, .i_inj_dbit, .i_rd_en, .o_rd_data, .o_full, .o_almost_full,
		.o_prog_full, .o_empty, .o_almost_empty, .o_prog_empty, .o_wr_ack, .o_overflow,
		.o_sbit_err, .o_dbit_err, .o_wr_count, .o_rd_count, .psel, .penable, .pwrite,
		.paddr, .pwdata, .prdata, .pready, .pslverr);
	cfb_user_model cfb_user_model_i (.i_want_wr(want_wr), .i_want_rd(want_rd),
		.i_obey(obey), .i_data(wdat), .i_full(o_full), .i_empty(o_empty),
		.o_wr_en(i_wr_en), .o_rd_en(i_rd_en), .o_wr_data(i_wr_data));

	// ====================
	// Helpers
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : xs

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			err_total++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	// One cycle of user intent, launched just after a rising edge
	task automatic cyc(input logic w, input logic rr, input logic ob, input logic s,
		input logic d);
		want_wr <= w;
		want_rd <= rr;
		obey <= ob;
		i_inj_sbit <= s;
		i_inj_dbit <= d;
		wdat <= xs();
		@(posedge i_clk);
	endtask : cyc

	// APB transfer; one idle edge after it so psel is never set twice at once
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge i_clk);
		penable <= 1'b1;
		do @(posedge i_clk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge i_clk);
	endtask : apb

	task automatic test_done;
		$display("checks %0d errors %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : test_done

	// ====================
	// Reference model, updated on the edge that takes requests
	always @(posedge i_clk)
	begin
		if (rel < 3)
		begin
			q.delete();
			cnt = 0;
			due = 0;
		end
		wacc = i_wr_en && cnt < 16;
		racc = i_rd_en && cnt > 0;
		eack = wacc;
		eovf = i_wr_en && !wacc;
		due = {due[0], racc};
		if (wacc)
			q.push_back('{i_wr_data, i_inj_sbit && !i_inj_dbit, i_inj_dbit});
		cnt = cnt + int'(wacc) - int'(racc);
		if (cnt >= 12)
			pf = 1;
		else if (cnt < 8)
			pf = 0;
		if (cnt <= 4)
			pe = 1;
		else if (cnt > 8)
			pe = 0;
		ef = {cnt == 16, cnt == 15, cnt == 0, cnt == 1};
		idle = (i_wr_en || i_rd_en) ? 0 : idle + 1;
		rel = !i_rstn ? 0 : (rel < 4 ? rel + 1 : 4);
	end

	// Outputs compared mid-cycle, once the edge's updates have landed
	always @(negedge i_clk)
		if (i_rstn && rel == 4)
		begin
			chk({o_full, o_almost_full, o_empty, o_almost_empty}, ef);
			chk({o_prog_full, o_prog_empty}, {pf, pe});
			chk({o_wr_ack, o_overflow}, {eack, eovf});
			chk(o_wr_count, cnt[4:1]);
			if (idle > 4)
				chk(o_rd_count, cnt[4:1]);
			if (due[1])
			begin
				e = q.pop_front();
				if (!e.db)
					chk(o_rd_data, e.d);
				chk({o_sbit_err, o_dbit_err}, {e.sb, e.db});
			end
		end

	// ====================
	// Scenarios
	initial
	begin
		repeat (12) @(posedge i_clk);
		i_rstn <= 1'b1;
		repeat (5) @(posedge i_clk);
		repeat (20) cyc(1, 0, 1, 0, 0);
		repeat (2) cyc(1, 0, 0, 0, 0);
		cyc(0, 0, 1, 0, 0);
		apb(1'b0, CFB_OFS_STATUS, 0);
		chk(rd, (32'h1 << CFB_ST_FULL) | (32'h1 << CFB_ST_PFULL) | (32'h1 << CFB_ST_OVF));
		apb(1'b1, CFB_OFS_STATUS, 32'h1 << CFB_ST_OVF);
		apb(1'b0, CFB_OFS_STATUS, 0);
		chk(rd, (32'h1 << CFB_ST_FULL) | (32'h1 << CFB_ST_PFULL));
		apb(1'b0, 8'h0c, 0);
		chk({rd[30:0], er}, 32'h1);
		repeat (20) cyc(0, 1, 1, 0, 0);
		repeat (2) cyc(0, 1, 0, 0, 0);
		for (int i = 0; i < 200; i++)
		begin
			r = xs();
			cyc(r[0] | (i[5] & r[1]), r[2] | (!i[5] & r[3]), 1, r[6:4] == 0, r[9:6] == 0);
		end
		cyc(0, 0, 1, 0, 0);
		repeat (6) @(posedge i_clk);
		i_rstn <= 1'b0;
		@(negedge i_clk);
		chk({o_full, o_almost_full, o_prog_full}, 3'b111);
		@(negedge i_clk);
		chk(o_rd_data, RSTV);
		repeat (12) @(posedge i_clk);
		i_rstn <= 1'b1;
		repeat (5) @(posedge i_clk);
		repeat (3) cyc(1, 1, 1, 0, 0);
		repeat (6) cyc(0, 1, 1, 0, 0);
		test_done();
	end

	// Watchdog, well beyond the few hundred cycles the scenarios take
	initial
	begin
		repeat (3000) @(posedge i_clk);
		err_total++;
		test_done();
	end
endmodule : cfb_fifo_tb

bind cfb_fifo cfb_fifo_asserts #(.WR_WIDTH(WR_WIDTH)) cfb_fifo_asserts_i (
	.i_clk, .i_rstn, .i_wr_en, .i_rd_en, .o_rd_data, .o_full, .o_almost_full,
	.o_prog_full, .o_empty, .o_almost_empty, .o_wr_ack, .o_overflow,
	.o_sbit_err, .o_dbit_err);
